// File: rtl/ebtl_params.svh
// Offsets, field positions, reset values and prescaler taps of the lower timer
// Assumes inclusion by bare name from the package and the timer module
`ifndef EBTL_PARAMS_SVH
`define EBTL_PARAMS_SVH

`define EBTL_ADDR_W 8
`define EBTL_OFF_CONTROL 8'h1a
`define EBTL_OFF_PERIOD 8'h1e
`define EBTL_OFF_WIDTH 8'h2e

`define EBTL_CTRL_MODE_LSB 0
`define EBTL_CTRL_RUN_BIT 3
`define EBTL_CTRL_CLK_LSB 4
`define EBTL_CTRL_RESET 7'h00
`define EBTL_CMP_RESET 8'hff

`define EBTL_PRESCALE_W 11
`define EBTL_TAP_DIV2 1
`define EBTL_TAP_DIV8 3
`define EBTL_TAP_DIV32 5
`define EBTL_TAP_DIV128 7
`define EBTL_TAP_DIV2048 11
`define EBTL_LF_TAP 3

`endif

// File: rtl/ebtl_pkg.sv
// Types shared by the lower timer and whoever drives its register port
// Assumes ebtl_params.svh sits beside it on the include path
package ebtl_pkg;
    `include "ebtl_params.svh"

    typedef enum logic [2:0] {
        EBTL_MODE_8BIT = 3'h0,
        EBTL_MODE_RSV1 = 3'h1,
        EBTL_MODE_RSV2 = 3'h2,
        EBTL_MODE_16BIT = 3'h3
    } ebtl_mode_type;

    typedef enum logic [2:0] {
        EBTL_CLK_SLOWEST = 3'h0,
        EBTL_CLK_HF_DIV128 = 3'h1,
        EBTL_CLK_HF_DIV32 = 3'h2,
        EBTL_CLK_HF_DIV8 = 3'h3,
        EBTL_CLK_LF = 3'h4,
        EBTL_CLK_HF_DIV2 = 3'h5,
        EBTL_CLK_HF = 3'h6,
        EBTL_CLK_RSV = 3'h7
    } ebtl_clk_type;

    // Upper timer modes that cascade the pair
    typedef enum logic [2:0] {
        EBTL_UP_16TIMER = 3'h4,
        EBTL_UP_WARMUP = 3'h5,
        EBTL_UP_16PWM = 3'h6
    } ebtl_upper_mode_type;

    typedef struct packed {
        ebtl_clk_type clock_sel;
        logic run;
        ebtl_mode_type mode;
    } ebtl_ctrl_type;

    typedef struct packed {
        logic [`EBTL_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ebtl_bus_req_type;

    // Fields of the upper timer control that steer a cascaded pair
    typedef struct packed {
        logic [2:0] mode;
        logic run;
        logic flop_init;
    } ebtl_upper_type;
endpackage

// File: rtl/ebtl_timer.sv
// Lower 8-bit timer of a cascadable pair: control, compare registers, counter
// Assumes hf_tick and lf_tick are one-cycle enables made on core_clk, and
// that the upper timer's control fields arrive on core_clk as well.
//
// Behaviour
// - One control register and two 8-bit compare registers, period and width.
// - Period and width compare registers reset to all ones.
// - Full speed: codes pick high or low clock taps; 000 follows divider tap; 111 reserved.
// - Low speed: only low clock /8 and low clock; high clock only for warm-up.
// - Run bit 0 stops and clears the counter; 1 starts counting.
// - Mode 000 is standalone 8-bit, 011 cascaded 16-bit, others reserved.
// - Cascaded: own clock selector; upper run bit and upper flop init rule.
// - Control bits 6..0 reset to zero; bit 7 unimplemented.
// - Upper timer in a 16-bit mode counts the lower overflow.
// - Upper modes 100, 101, 110 are the cascaded operations.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "ebtl_params.svh"

module ebtl_timer (
    input wire logic core_clk,
    input wire logic srst,
    input wire ebtl_pkg::ebtl_bus_req_type bus_req,
    output logic [7:0] rd_data,
    input wire logic hf_tick,
    input wire logic lf_tick,
    input wire logic low_speed_mode,
    input wire logic divider_tap_select,
    input wire ebtl_pkg::ebtl_upper_type upper_ctrl,
    output logic [7:0] count_value,
    output logic period_match,
    output logic lower_overflow,
    output logic timer_flop,
    output logic running
);
    import ebtl_pkg::*;

    ebtl_ctrl_type lower_timer_control;
    logic [7:0] lower_period_compare;
    logic [7:0] lower_width_compare;
    logic [`EBTL_PRESCALE_W-1:0] hf_div;
    logic [`EBTL_LF_TAP-1:0] lf_div;
    logic [7:0] count;

    // Pulse when the high-frequency prescaler has just completed a 2^n span
    function automatic logic hf_tap(input logic [`EBTL_PRESCALE_W-1:0] div, input int n);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < `EBTL_PRESCALE_W; i++) begin
            if (i < n && !div[i]) begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction

    wire sel_ctrl = bus_req.addr == `EBTL_OFF_CONTROL;
    wire sel_period = bus_req.addr == `EBTL_OFF_PERIOD;
    wire sel_width = bus_req.addr == `EBTL_OFF_WIDTH;
    wire wr_ctrl = bus_req.wr && sel_ctrl;
    wire wr_period = bus_req.wr && sel_period;
    wire wr_width = bus_req.wr && sel_width;

    wire tick_hf = hf_tick;
    wire tick_hf2 = hf_tick && hf_tap(hf_div, `EBTL_TAP_DIV2);
    wire tick_hf8 = hf_tick && hf_tap(hf_div, `EBTL_TAP_DIV8);
    wire tick_hf32 = hf_tick && hf_tap(hf_div, `EBTL_TAP_DIV32);
    wire tick_hf128 = hf_tick && hf_tap(hf_div, `EBTL_TAP_DIV128);
    wire tick_hf2048 = hf_tick && hf_tap(hf_div, `EBTL_TAP_DIV2048);
    wire tick_lf8 = lf_tick && (&lf_div);

    wire cascaded = lower_timer_control.mode == EBTL_MODE_16BIT;
    wire upper_cascade_mode = upper_ctrl.mode[2] && upper_ctrl.mode != 3'h7;
    wire upper_warmup = upper_ctrl.mode == EBTL_UP_WARMUP;
    wire mode_valid = lower_timer_control.mode == EBTL_MODE_8BIT || cascaded;
    // Cascaded pair starts and stops from the upper run bit
    wire run_effective = cascaded ? upper_ctrl.run : lower_timer_control.run;

    // Count source, full speed and low speed tables
    logic src_tick;
    logic src_valid;
    always_comb begin
        src_tick = 1'b0;
        src_valid = 1'b1;
        if (low_speed_mode) begin
            case (lower_timer_control.clock_sel)
                EBTL_CLK_SLOWEST: src_tick = tick_lf8;
                EBTL_CLK_LF: src_tick = lf_tick;
                EBTL_CLK_HF: begin
                    src_valid = cascaded && upper_warmup;
                    src_tick = tick_hf;
                end
                default: src_valid = 1'b0;
            endcase
        end else begin
            case (lower_timer_control.clock_sel)
                EBTL_CLK_SLOWEST: src_tick = divider_tap_select ? tick_lf8 : tick_hf2048;
                EBTL_CLK_HF_DIV128: src_tick = tick_hf128;
                EBTL_CLK_HF_DIV32: src_tick = tick_hf32;
                EBTL_CLK_HF_DIV8: src_tick = tick_hf8;
                EBTL_CLK_LF: src_tick = lf_tick;
                EBTL_CLK_HF_DIV2: src_tick = tick_hf2;
                EBTL_CLK_HF: src_tick = tick_hf;
                default: src_valid = 1'b0;
            endcase
        end
    end

    // Reserved settings hold the count instead of guessing a source
    wire count_en = run_effective && src_valid && mode_valid && src_tick;
    wire hit_period = !cascaded && count == lower_period_compare;
    wire wrap = cascaded && count == 8'hff;
    wire [7:0] next_count = (hit_period || wrap) ? 8'h00 : 8'(count + 8'h01);
    wire next_flop_init = cascaded ? upper_ctrl.flop_init : 1'b0;

    wire [7:0] ctrl_read = {1'b0, lower_timer_control};
    wire [7:0] next_rd_data = !bus_req.rd ? 8'h00 :
                              sel_ctrl ? ctrl_read :
                              sel_period ? lower_period_compare :
                              sel_width ? lower_width_compare : 8'h00;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            lower_timer_control <= ebtl_ctrl_type'(`EBTL_CTRL_RESET);
            lower_period_compare <= `EBTL_CMP_RESET;
            lower_width_compare <= `EBTL_CMP_RESET;
        end else begin
            // Bit 7 has no storage; reads return zero there
            if (wr_ctrl) begin
                lower_timer_control <= ebtl_ctrl_type'(bus_req.wdata[6:0]);
            end
            if (wr_period) begin
                lower_period_compare <= bus_req.wdata;
            end
            if (wr_width) begin
                lower_width_compare <= bus_req.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            hf_div <= '0;
            lf_div <= '0;
        end else begin
            if (hf_tick) begin
                hf_div <= hf_div + 1'b1;
            end
            if (lf_tick) begin
                lf_div <= lf_div + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            count <= 8'h00;
            period_match <= 1'b0;
            lower_overflow <= 1'b0;
        end else begin
            period_match <= count_en && hit_period;
            lower_overflow <= count_en && wrap && upper_cascade_mode;
            if (!run_effective) begin
                count <= 8'h00;
            end else if (count_en) begin
                count <= next_count;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            timer_flop <= 1'b0;
            running <= 1'b0;
            count_value <= 8'h00;
            rd_data <= 8'h00;
        end else begin
            // Initial level is loaded only while stopped
            if (!run_effective) begin
                timer_flop <= next_flop_init;
            end
            running <= run_effective;
            count_value <= count;
            rd_data <= next_rd_data;
        end
    end

    AST_CTRL_RESET: assert property (@(posedge core_clk) srst |=> lower_timer_control == 7'h00)
        else $error("control not zero after reset");
    AST_CMP_RESET: assert property (@(posedge core_clk) srst |=>
        lower_period_compare == 8'hff && lower_width_compare == 8'hff)
        else $error("compare registers not all ones after reset");
    AST_STOP_CLEARS: assert property (@(posedge core_clk) disable iff (srst)
        !run_effective |=> count == 8'h00)
        else $error("counter not cleared while stopped");
    AST_CASCADE_RUN: assert property (@(posedge core_clk) disable iff (srst)
        cascaded && !upper_ctrl.run |=> !running)
        else $error("cascaded pair ran without upper run bit");
    AST_RESERVED_HOLD: assert property (@(posedge core_clk) disable iff (srst)
        run_effective && (!mode_valid || !src_valid) |=> $stable(count))
        else $error("counter moved on reserved setting");
    AST_LOW_SPEED_HF: assert property (@(posedge core_clk) disable iff (srst)
        low_speed_mode && lower_timer_control.clock_sel == EBTL_CLK_HF && !upper_warmup |-> !count_en)
        else $error("high clock counted in low speed outside warm-up");
    AST_PERIOD_WRAP: assert property (@(posedge core_clk) disable iff (srst)
        count_en && hit_period |=> count == 8'h00 && period_match)
        else $error("period match did not clear counter");
    AST_OVERFLOW: assert property (@(posedge core_clk) disable iff (srst)
        lower_overflow |-> $past(count) == 8'hff && cascaded)
        else $error("overflow without lower wrap");
    AST_WRITE_TAKEN: assert property (@(posedge core_clk) disable iff (srst)
        wr_width |=> lower_width_compare == $past(bus_req.wdata))
        else $error("width compare write lost");
    AST_LF_TAP: assert property (@(posedge core_clk) disable iff (srst)
        run_effective && mode_valid && !low_speed_mode && lower_timer_control.clock_sel == EBTL_CLK_LF
        && !lf_tick |=> $stable(count))
        else $error("low clock source counted without its tick");
endmodule

`default_nettype wire

// File: bench/ebtl_timer_tb.sv
// Bench for the lower 8-bit timer: register port tasks, clock-source table, cascade
// Assumes the design files under rtl/ are compiled first and the include path reaches rtl/
`timescale 1ns/100ps
`default_nettype none
`include "ebtl_params.svh"

module eight_bit_timer_lower_control_tb_top;
    import ebtl_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    ebtl_bus_req_type bus = '0;
    logic hf_tick = 1'b1;
    logic lf_tick = 1'b0;
    logic low_speed_mode = 1'b0;
    logic divider_tap_select = 1'b0;
    ebtl_upper_type upper = '0;
    logic [7:0] rd_data;
    logic [7:0] count_value;
    logic period_match;
    logic lower_overflow;
    logic timer_flop;
    logic running;
    logic [1:0] lf_div = 2'h0;
    int error_cnt = 0;
    int tests_run = 0;

    ebtl_timer dut (
        .core_clk(core_clk),
        .srst(srst),
        .bus_req(bus),
        .rd_data(rd_data),
        .hf_tick(hf_tick),
        .lf_tick(lf_tick),
        .low_speed_mode(low_speed_mode),
        .divider_tap_select(divider_tap_select),
        .upper_ctrl(upper),
        .count_value(count_value),
        .period_match(period_match),
        .lower_overflow(lower_overflow),
        .timer_flop(timer_flop),
        .running(running)
    );

    initial forever #5 core_clk = ~core_clk;

    // Slow clock at a quarter of the core rate keeps code 100 apart from the fast ones; low clock /8 equals high clock /32
    always @(posedge core_clk) begin
        lf_div <= lf_div + 2'h1;
        lf_tick <= (lf_div == 2'h3);
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        @(negedge core_clk);
        check({8'h00, rd_data}, {8'h00, exp});
    endtask

    // Cycles between two pulses of the chosen output, once the first one is seen
    task automatic measure(input logic sel, input int exp);
        int n;
        n = 0;
        @(negedge core_clk);
        while (((sel ? lower_overflow : period_match) !== 1'b1) && n < 20000) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (((sel ? lower_overflow : period_match) !== 1'b1) && n < 20000);
        check(n[15:0], exp[15:0]);
    endtask

    task automatic cfg(input logic [2:0] clk, input logic ls, input logic tap, input int exp);
        @(posedge core_clk);
        low_speed_mode <= ls;
        divider_tap_select <= tap;
        wr(`EBTL_OFF_CONTROL, {1'b0, clk, 1'b1, 3'h0});
        measure(1'b0, exp);
        check({15'h0, running}, 16'h1);
        wr(`EBTL_OFF_CONTROL, {1'b0, clk, 1'b0, 3'h0});
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        check({8'h00, count_value}, 16'h0);
    endtask

    task automatic held(input logic [7:0] ctrl, input logic ls);
        @(posedge core_clk);
        low_speed_mode <= ls;
        wr(`EBTL_OFF_CONTROL, ctrl);
        repeat (40) @(posedge core_clk);
        @(negedge core_clk);
        check({8'h00, count_value}, 16'h0);
        wr(`EBTL_OFF_CONTROL, ctrl & 8'hf7);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #600000;
        error_cnt++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        rd(`EBTL_OFF_CONTROL, 8'h00);
        rd(`EBTL_OFF_PERIOD, 8'hff);
        rd(`EBTL_OFF_WIDTH, 8'hff);
        rd(8'h20, 8'h00);
        wr(`EBTL_OFF_CONTROL, 8'hf7);
        rd(`EBTL_OFF_CONTROL, 8'h77);
        wr(`EBTL_OFF_CONTROL, 8'h00);
        wr(`EBTL_OFF_PERIOD, 8'h5a);
        wr(`EBTL_OFF_WIDTH, 8'ha5);
        wr(8'h20, 8'h33);
        rd(8'h20, 8'h00);
        rd(`EBTL_OFF_PERIOD, 8'h5a);
        rd(`EBTL_OFF_WIDTH, 8'ha5);
        // Period 2 gives three counts per match
        wr(`EBTL_OFF_PERIOD, 8'h02);
        cfg(3'h6, 1'b0, 1'b0, 3);
        cfg(3'h5, 1'b0, 1'b0, 6);
        cfg(3'h3, 1'b0, 1'b0, 24);
        cfg(3'h2, 1'b0, 1'b0, 96);
        cfg(3'h1, 1'b0, 1'b0, 384);
        cfg(3'h0, 1'b0, 1'b0, 6144);
        cfg(3'h0, 1'b0, 1'b1, 96);
        cfg(3'h4, 1'b0, 1'b0, 12);
        cfg(3'h0, 1'b1, 1'b0, 96);
        cfg(3'h4, 1'b1, 1'b0, 12);
        held(8'h78, 1'b0);
        held(8'h69, 1'b0);
        held(8'h6a, 1'b0);
        held(8'h68, 1'b1);
        held(8'h18, 1'b1);
        // Cascade: lower run bit stays clear, the upper fields govern start and flop
        @(posedge core_clk);
        low_speed_mode <= 1'b0;
        wr(`EBTL_OFF_CONTROL, 8'h63);
        for (int m = 4; m < 7; m++) begin
            @(posedge core_clk);
            upper <= {m[2:0], 1'b0, m[0]};
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            check({15'h0, timer_flop}, {15'h0, m[0]});
            @(posedge core_clk);
            upper.run <= 1'b1;
            measure(1'b1, 256);
            @(posedge core_clk);
            upper.run <= 1'b0;
        end
        rd(`EBTL_OFF_CONTROL, 8'h63);
        stop_test();
    end
endmodule

`default_nettype wire
